// ### src/ffb_flag_bank.sv
// Behaviour
// - Second mask register: one bit per source except standby, 1 masks, reset clears to 0.
// - Wake input one mask at bit 8, wake input two mask at bit 9.
// - Link communication error mask at bit 22 blocks those interrupts.
// - Die temperature event mask at bit 23 blocks those interrupts.
// - Thermal self-test error mask at bit 18 blocks self-test interrupts.
// - Pre-regulator masks: uv high 13, uv low 14, overcurrent 15, overvoltage 16.
// - Regulator over-temperature flags latch at bits 8 through 15.
// - Overcurrent flags at bits 16 to 21 and 23; bit 22 reserved, zero.
// - Reset clears all flags; writing 1 to a flag bit clears it unless its event sets it again in the same cycle.
// - Wake flags at bits 8 and 9 set only on rising wake edges.
// - Battery and pre-regulator supply event flags latch at bits 10 to 15.
// - Upper byte flags: prereg ov, hv uv, standby, boost events, bits 16-21.
// - Self-test failure flag at bit 22, 1 means failed, held until cleared.
// - Die temperature event flag latches at bit 23.
// - First mask register masks over-temperature and overcurrent flags, 1 inhibits.
`timescale 1ns/100ps
module ffb_flag_bank (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire ffb_pkg::ffb_reg_idx_t reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire ffb_pkg::ffb_word_t reg_wdata,
  output ffb_pkg::ffb_word_t reg_rdata,
  output logic reg_rd_valid,
  input wire logic wake_input_one,
  input wire logic wake_input_two,
  input wire logic [7:0] overtemp_evt,
  input wire logic [6:0] overcurrent_evt,
  input wire logic [2:0] battery_uv_evt,
  input wire logic [3:0] prereg_evt,
  input wire logic hv_linear_input_uv_evt,
  input wire logic standby_timer_evt,
  input wire logic [2:0] boost_evt,
  input wire logic thermal_selftest_fail,
  input wire logic die_temp_evt,
  input wire logic link_comm_error_pending,
  output logic irq_out
);
  import ffb_pkg::*;

  ffb_word_t irq_mask_regulator_r;
  ffb_word_t irq_mask_supply_events_r;
  ffb_word_t regulator_fault_flags_r;
  ffb_word_t supply_wake_event_flags_r;
  ffb_word_t regulator_fault_flags_nxt;
  ffb_word_t supply_wake_event_flags_nxt;
  ffb_word_t set1;
  ffb_word_t set2;
  ffb_word_t mask2_aligned;
  ffb_word_t rdata_nxt;
  ffb_sync_vec_t sync_lvl;
  logic [1:0] wake_rise;
  logic irq_nxt;
  logic irq_from_regulator;
  logic irq_from_supply;
  logic irq_from_link;
  logic flag1_wr_hit;
  logic flag2_wr_hit;

  // Word index of a printed bit position
  function automatic int unsigned pos(input int unsigned printed);
    pos = printed - `FFB_BIT_BASE;
  endfunction : pos

  // Clear on write-one, set wins over clear, write-zero leaves flag
  function automatic ffb_word_t w1c_next(input ffb_word_t cur, input ffb_word_t set,
                                         input logic hit, input ffb_word_t wdata);
    ffb_word_t clr;
    clr = hit ? wdata : 16'h0000;
    w1c_next = (cur & ~clr) | set;
  endfunction : w1c_next

  // Write strobe aimed at one register index
  function automatic logic wr_hit(input logic wr_en, input ffb_reg_idx_t addr,
                                  input ffb_reg_idx_t idx);
    wr_hit = wr_en && (addr == idx);
  endfunction : wr_hit

  // Any flag set whose mask bit is clear
  function automatic logic any_pending(input ffb_word_t flags, input ffb_word_t mask);
    any_pending = |(flags & ~mask);
  endfunction : any_pending

  ffb_sync u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .async_in({die_temp_evt, thermal_selftest_fail, boost_evt, standby_timer_evt,
               hv_linear_input_uv_evt, prereg_evt, battery_uv_evt, overcurrent_evt,
               overtemp_evt, wake_input_two, wake_input_one}),
    .sync_out(sync_lvl),
    .wake_rise(wake_rise)
  );

  // Regulator event word: over-temperature low byte, overcurrent upper byte
  always_comb begin
    set1 = 16'h0000;
    set1[pos(`FFB_B_OT_FIRST) +: 8] = sync_lvl[9:2];
    set1[pos(`FFB_B_OC_FIRST) +: 6] = sync_lvl[15:10];
    set1[pos(`FFB_B_OC_HV)] = sync_lvl[16];
    set1[pos(`FFB_B_OC_RSVD)] = 1'b0;
  end

  // Supply and wake event word
  always_comb begin
    set2 = 16'h0000;
    set2[pos(`FFB_B_WAKE1)] = wake_rise[0];
    set2[pos(`FFB_B_WAKE2)] = wake_rise[1];
    set2[pos(`FFB_B_BAT_UVH)] = sync_lvl[17];
    set2[pos(`FFB_B_BAT_UVL)] = sync_lvl[18];
    set2[pos(`FFB_B_BAT_UV3)] = sync_lvl[19];
    set2[pos(`FFB_B_PRE_UVH)] = sync_lvl[20];
    set2[pos(`FFB_B_PRE_UVL)] = sync_lvl[21];
    set2[pos(`FFB_B_PRE_OC)] = sync_lvl[22];
    set2[pos(`FFB_B_PRE_OV)] = sync_lvl[23];
    set2[pos(`FFB_B_HV_UV)] = sync_lvl[24];
    set2[pos(`FFB_B_STBY)] = sync_lvl[25];
    set2[pos(`FFB_B_BOOST_OV)] = sync_lvl[26];
    set2[pos(`FFB_B_BOOST_UVH)] = sync_lvl[27];
    set2[pos(`FFB_B_BOOST_SUP)] = sync_lvl[28];
    set2[pos(`FFB_B_SELFTEST)] = sync_lvl[29];
    set2[pos(`FFB_B_DIE_TEMP)] = sync_lvl[30];
  end

  // First mask register
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      irq_mask_regulator_r <= `FFB_MASK_RST;
    end else if (ce && wr_hit(reg_wr_en, reg_addr, FFB_IDX_MASK1)) begin
      irq_mask_regulator_r <= reg_wdata & `FFB_FLAG1_IMPL;
    end
  end

  // Second mask register
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      irq_mask_supply_events_r <= `FFB_MASK_RST;
    end else if (ce && wr_hit(reg_wr_en, reg_addr, FFB_IDX_MASK2)) begin
      irq_mask_supply_events_r <= reg_wdata;
    end
  end

  assign flag1_wr_hit = wr_hit(reg_wr_en, reg_addr, FFB_IDX_FLAG1);
  assign flag2_wr_hit = wr_hit(reg_wr_en, reg_addr, FFB_IDX_FLAG2);

  assign regulator_fault_flags_nxt = w1c_next(regulator_fault_flags_r, set1, flag1_wr_hit,
                                              reg_wdata) & `FFB_FLAG1_IMPL;
  assign supply_wake_event_flags_nxt = w1c_next(supply_wake_event_flags_r, set2, flag2_wr_hit,
                                                reg_wdata);

  // Sticky regulator flags
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      regulator_fault_flags_r <= `FFB_FLAG_RST;
    end else if (ce) begin
      regulator_fault_flags_r <= regulator_fault_flags_nxt;
    end
  end

  // Sticky supply and wake flags
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      supply_wake_event_flags_r <= `FFB_FLAG_RST;
    end else if (ce) begin
      supply_wake_event_flags_r <= supply_wake_event_flags_nxt;
    end
  end

  // Second mask lined up with the supply flag word; standby flag always masked, never interrupts
  always_comb begin
    mask2_aligned = irq_mask_supply_events_r;
    mask2_aligned[pos(`FFB_B_STBY)] = 1'b1;
    mask2_aligned[pos(`FFB_B_SELFTEST)] = irq_mask_supply_events_r[pos(`FFB_B_M_SELFTEST)];
    mask2_aligned[pos(`FFB_B_DIE_TEMP)] = irq_mask_supply_events_r[pos(`FFB_B_DIE_TEMP)];
  end

  assign irq_from_regulator = any_pending(regulator_fault_flags_r,
                                          irq_mask_regulator_r);
  assign irq_from_supply = any_pending(supply_wake_event_flags_r, mask2_aligned);
  assign irq_from_link = link_comm_error_pending
                       & ~irq_mask_supply_events_r[pos(`FFB_B_M_COMM)];
  assign irq_nxt = irq_from_regulator | irq_from_supply | irq_from_link;

  // Interrupt output
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      irq_out <= 1'b0;
    end else if (ce) begin
      irq_out <= irq_nxt;
    end
  end

  // Read mux
  always_comb begin
    case (reg_addr)
      FFB_IDX_MASK1: rdata_nxt = irq_mask_regulator_r;
      FFB_IDX_MASK2: rdata_nxt = irq_mask_supply_events_r;
      FFB_IDX_FLAG1: rdata_nxt = regulator_fault_flags_r;
      FFB_IDX_FLAG2: rdata_nxt = supply_wake_event_flags_r;
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // Read answer strobe
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      reg_rd_valid <= 1'b0;
    end else if (ce) begin
      reg_rd_valid <= reg_rd_en;
    end
  end

  // Read data register, holds until the next read
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (ce && reg_rd_en) begin
      reg_rdata <= rdata_nxt;
    end
  end
endmodule : ffb_flag_bank

// ### src/ffb_params.svh
`ifndef FFB_PARAMS_SVH
`define FFB_PARAMS_SVH

// Word bit 0 carries register bit 8
`define FFB_BIT_BASE 8

// Register indices on the register port
`define FFB_REG_MASK1 2'h0
`define FFB_REG_MASK2 2'h1
`define FFB_REG_FLAG1 2'h2
`define FFB_REG_FLAG2 2'h3

// Reset values
`define FFB_MASK_RST 16'h0000
`define FFB_FLAG_RST 16'h0000

// Implemented bits of the regulator flag word, bit 22 reserved
`define FFB_FLAG1_IMPL 16'hBFFF

// Printed bit positions
`define FFB_B_WAKE1 8
`define FFB_B_WAKE2 9
`define FFB_B_BAT_UVH 10
`define FFB_B_BAT_UVL 11
`define FFB_B_BAT_UV3 12
`define FFB_B_PRE_UVH 13
`define FFB_B_PRE_UVL 14
`define FFB_B_PRE_OC 15
`define FFB_B_PRE_OV 16
`define FFB_B_HV_UV 17
`define FFB_B_STBY 18
`define FFB_B_M_SELFTEST 18
`define FFB_B_BOOST_OV 19
`define FFB_B_BOOST_UVH 20
`define FFB_B_BOOST_SUP 21
`define FFB_B_SELFTEST 22
`define FFB_B_M_COMM 22
`define FFB_B_DIE_TEMP 23
`define FFB_B_OT_FIRST 8
`define FFB_B_OC_FIRST 16
`define FFB_B_OC_RSVD 22
`define FFB_B_OC_HV 23

// Width of the synchronised event bundle
`define FFB_SYNC_W 31

`endif

// ### src/ffb_pkg.sv
package ffb_pkg;
  `include "ffb_params.svh"

  typedef logic [15:0] ffb_word_t;

  typedef enum logic [1:0] {
    FFB_IDX_MASK1 = `FFB_REG_MASK1,
    FFB_IDX_MASK2 = `FFB_REG_MASK2,
    FFB_IDX_FLAG1 = `FFB_REG_FLAG1,
    FFB_IDX_FLAG2 = `FFB_REG_FLAG2
  } ffb_reg_idx_t;

  typedef logic [`FFB_SYNC_W-1:0] ffb_sync_vec_t;
endpackage : ffb_pkg

// ### src/ffb_sync.sv
`timescale 1ns/100ps
module ffb_sync (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire ffb_pkg::ffb_sync_vec_t async_in,
  output ffb_pkg::ffb_sync_vec_t sync_out,
  output logic [1:0] wake_rise
);
  import ffb_pkg::*;

  ffb_sync_vec_t meta_r;
  ffb_sync_vec_t sync_r;
  logic [1:0] wake_prev_r;

  // Two-stage synchroniser
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (ce) begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  // Rising edge of the two wake inputs
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wake_prev_r <= 2'h0;
    end else if (ce) begin
      wake_prev_r <= sync_r[1:0];
    end
  end

  assign sync_out = sync_r;
  assign wake_rise = sync_r[1:0] & ~wake_prev_r;
endmodule : ffb_sync

// ### tb/ffb_chk.sv
`timescale 1ns/100ps
module ffb_chk
  import ffb_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic reg_rd_en,
  input wire ffb_pkg::ffb_reg_idx_t reg_addr,
  input wire ffb_pkg::ffb_word_t reg_rdata,
  input wire logic reg_rd_valid,
  input wire logic irq_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_read_answer: assert property (ce && reg_rd_en |=> reg_rd_valid)
    else $error("read not answered");
  a_valid_cause: assert property (reg_rd_valid && $past(ce) |-> $past(reg_rd_en))
    else $error("valid without read");
  a_flag1_rsvd: assert property (
    reg_rd_valid && $past(reg_addr) == FFB_IDX_FLAG1 |-> !reg_rdata[14])
    else $error("flag1 reserved bit set");
  a_mask1_rsvd: assert property (
    reg_rd_valid && $past(reg_addr) == FFB_IDX_MASK1 |-> !reg_rdata[14])
    else $error("mask1 reserved bit set");
  a_rdata_hold: assert property (!reg_rd_valid |-> $stable(reg_rdata))
    else $error("read data moved");
  a_reset_quiet: assert property ($rose(nrst) |-> !irq_out && !reg_rd_valid)
    else $error("outputs busy after reset");
  a_reset_rdata: assert property ($rose(nrst) |-> reg_rdata == 16'h0000)
    else $error("read data not cleared");
  a_freeze_hold: assert property (!ce |=> $stable(irq_out))
    else $error("irq moved while frozen");
endmodule : ffb_chk

bind ffb_flag_bank ffb_chk u_ffb_chk(.core_clk(core_clk), .nrst(nrst), .ce(ce),
  .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .reg_rd_valid(reg_rd_valid), .irq_out(irq_out));

// ### tb/ffb_flag_bank_bench.sv
`timescale 1ns/100ps
module ffb_flag_bank_bench;
  import ffb_pkg::*;
  logic core_clk, nrst, ce, reg_wr_en, reg_rd_en, reg_rd_valid, irq_out, v;
  ffb_reg_idx_t reg_addr;
  ffb_word_t reg_wdata, reg_rdata, rd;
  logic [31:0] ev;
  int fails, cmp_count;
  int eb[12] = '{29, 30, 15, 18, 19, 20, 21, 27, 28, 31, 0, 14};
  ffb_word_t mw[12] = '{16'h0001, 16'h0002, 16'h0004, 16'h0020, 16'h0040, 16'h0080,
    16'h0100, 16'h0400, 16'h8000, 16'h4000, 16'h0001, 16'h8000};
  ffb_flag_bank u_ffb_flag_bank(.core_clk(core_clk), .nrst(nrst), .ce(ce),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .wake_input_one(ev[29]), .wake_input_two(ev[30]), .overtemp_evt(ev[7:0]),
    .overcurrent_evt(ev[14:8]), .battery_uv_evt(ev[17:15]), .prereg_evt(ev[21:18]),
    .hv_linear_input_uv_evt(ev[22]), .standby_timer_evt(ev[23]), .boost_evt(ev[26:24]),
    .thermal_selftest_fail(ev[27]), .die_temp_evt(ev[28]),
    .link_comm_error_pending(ev[31]), .irq_out(irq_out));
  ffb_host u_ffb_host(.core_clk(core_clk), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task chk(ffb_word_t got, ffb_word_t exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(ffb_reg_idx_t a, ffb_word_t d);
    u_ffb_host.put(a, 1'b1, d, rd, v);
  endtask : wr
  task rdc(ffb_reg_idx_t a);
    u_ffb_host.put(a, 1'b0, 16'h0000, rd, v);
    chk({15'h0000, v}, 16'h0001);
  endtask : rdc
  task irq(logic e);
    chk({15'h0000, irq_out}, {15'h0000, e});
  endtask : irq
  task t_reset_regs();
    for (int a = 0; a < 4; a++) begin
      rdc(ffb_reg_idx_t'(a));
      chk(rd, 16'h0000);
    end
  endtask : t_reset_regs
  task t_mask_rw();
    wr(FFB_IDX_MASK2, 16'hFFFF);
    wr(FFB_IDX_MASK1, 16'hFFFF);
    rdc(FFB_IDX_MASK2);
    chk(rd, 16'hFFFF);
    rdc(FFB_IDX_MASK1);
    chk(rd, 16'hBFFF);
    wr(FFB_IDX_MASK2, 16'h0000);
    wr(FFB_IDX_MASK1, 16'h0000);
  endtask : t_mask_rw
  task t_flag1();
    ev = 32'h0000_7FFF;
    tick(4);
    wr(FFB_IDX_FLAG1, 16'hFFFF);
    rdc(FFB_IDX_FLAG1);
    chk(rd, 16'hBFFF);
    irq(1'b1);
    ev = 32'h0000_0000;
    tick(3);
    wr(FFB_IDX_FLAG1, 16'h0000);
    rdc(FFB_IDX_FLAG1);
    chk(rd, 16'hBFFF);
    wr(FFB_IDX_FLAG1, 16'hFFFF);
    rdc(FFB_IDX_FLAG1);
    chk(rd, 16'h0000);
    irq(1'b0);
  endtask : t_flag1
  task t_flag2();
    ev = 32'h7FFF_8000;
    tick(4);
    rdc(FFB_IDX_FLAG2);
    chk(rd, 16'hFFFF);
    wr(FFB_IDX_FLAG2, 16'hFFFF);
    ev = 32'h0000_0000;
    tick(4);
    rdc(FFB_IDX_FLAG2);
    chk(rd, 16'hFFFC);
    wr(FFB_IDX_FLAG2, 16'hFFFF);
    ev[23] = 1'b1;
    tick(5);
    irq(1'b0);
    ev[23] = 1'b0;
    tick(3);
    wr(FFB_IDX_FLAG2, 16'hFFFF);
  endtask : t_flag2
  task t_masks();
    for (int i = 0; i < 12; i++) begin
      wr(i > 9 ? FFB_IDX_MASK1 : FFB_IDX_MASK2, mw[i]);
      ev[eb[i]] = 1'b1;
      tick(5);
      irq(1'b0);
      wr(i > 9 ? FFB_IDX_MASK1 : FFB_IDX_MASK2, 16'h0000);
      tick(1);
      irq(1'b1);
      ev = 32'h0000_0000;
      tick(3);
      u_ffb_host.clear_all();
      tick(1);
      irq(1'b0);
    end
  endtask : t_masks
  task t_freeze_reset();
    wr(FFB_IDX_MASK2, 16'h1234);
    ev[28] = 1'b1;
    tick(4);
    ce = 1'b0;
    ev = 32'h0000_0000;
    tick(3);
    ce = 1'b1;
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
    tick(1);
    rdc(FFB_IDX_FLAG2);
    chk(rd, 16'h0000);
    rdc(FFB_IDX_MASK2);
    chk(rd, 16'h0000);
  endtask : t_freeze_reset
  task report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    #1000000;
    fails++;
    report_and_stop();
  end
  initial begin
    fails = 0;
    cmp_count = 0;
    nrst = 1'b0;
    ce = 1'b1;
    ev = 32'h0000_0000;
    tick(16);
    nrst = 1'b1;
    tick(1);
    t_reset_regs();
    u_ffb_host.clear_all();
    t_mask_rw();
    t_flag1();
    t_flag2();
    t_masks();
    t_freeze_reset();
    report_and_stop();
  end
endmodule : ffb_flag_bank_bench

// ### tb/ffb_host.sv
`timescale 1ns/100ps
module ffb_host
  import ffb_pkg::*;
(
  input wire logic core_clk,
  input wire ffb_pkg::ffb_word_t reg_rdata,
  input wire logic reg_rd_valid,
  output ffb_pkg::ffb_reg_idx_t reg_addr,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output ffb_pkg::ffb_word_t reg_wdata
);
  initial begin
    reg_addr = FFB_IDX_MASK1;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wdata = 16'h0000;
  end
  // One strobe cycle, then the data bus shows garbage
  task automatic put(ffb_reg_idx_t a, logic w, ffb_word_t d, output ffb_word_t q,
                     output logic v);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = w;
    reg_rd_en = !w;
    @(posedge core_clk);
    #1;
    q = reg_rdata;
    v = reg_rd_valid;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wdata = ~d;
    @(posedge core_clk);
    #1;
  endtask : put
  task automatic clear_all();
    ffb_word_t q;
    logic v;
    put(FFB_IDX_FLAG1, 1'b1, 16'hFFFF, q, v);
    put(FFB_IDX_FLAG2, 1'b1, 16'hFFFF, q, v);
  endtask : clear_all
endmodule : ffb_host
